// File: hw/wwdr_top.sv
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns

// Function
// R01: after power-on keep reset output low for the reset hold time, then release.
// R02: reset output rising edge starts the ignore phase, 32 ms fast.
// R03: trigger input activity is disregarded during the ignore phase.
// R04: ignore phase end starts long open phase of four open times.
// R05: valid trigger in long open phase starts a closed phase at once.
// R06: only a high-to-low edge on the trigger input counts as trigger.
// R07: processor keeps trigger pulses long enough and before long open expiry.
// R08: closed phase end starts a standard open phase at once, 32 ms fast.
// R09: valid trigger ends a standard open phase at once.
// R10: standard open phase expiring without trigger drives reset output low.
// R11: trigger edge during closed phase drives reset output low.
// R12: processor triggers at a stable period landing inside open phases.
// R13: two strap inputs pick fast, slow or off; both low is fast.
// R14: output undervoltage indication drives reset output low.
// R15: on the low-voltage option, input undervoltage also drives reset low.
// R16: straps low-low fast, low-high slow, high-low fast, high-high off.
// R17: reset hold is fast 16 ms only with both straps low, else 32 ms.
// R18: processor avoids trigger pulses shorter than the minimum width.
// R19: after any watchdog reset hold reset low, then restart at ignore phase.
// R20: trigger ending a standard open phase starts a new closed phase.
// R21: slow timing doubles ignore, closed, open and long open phases.
module wwdr_top #(
  parameter int unsigned P_HOLD_FAST_CYC  = wwdr_pkg::HOLD_FAST_CYC,
  parameter int unsigned P_PHASE_FAST_CYC = wwdr_pkg::PHASE_FAST_CYC,
  parameter bit          P_OPT_LOW_VOUT   = 1'b0
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [31:0] o_prdata,
  // pins
  input  wire logic        i_watchdog_trigger_in,
  input  wire logic        i_timing_select_a,
  input  wire logic        i_timing_select_b,
  input  wire logic        i_vout_undervoltage,
  input  wire logic        i_vin_undervoltage,
  output logic             o_reset_out_pin_b,
  output logic             o_reset_out_oe
);

  localparam int unsigned CW        = wwdr_pkg::CNT_W;
  // bit positions of the pins inside the synchroniser vector
  localparam int unsigned PIN_N     = 5;
  localparam int unsigned PIN_TRIG  = 4;
  localparam int unsigned PIN_SEL_A = 3;
  localparam int unsigned PIN_SEL_B = 2;
  localparam int unsigned PIN_UV_O  = 1;
  localparam int unsigned PIN_UV_I  = 0;
  // only the trigger idles high; straps and comparators start low
  localparam logic [PIN_N-1:0] PIN_INIT = PIN_N'(1) << PIN_TRIG;

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  // the longest span is a slow long open phase: eight fast open phases
  if (P_HOLD_FAST_CYC < 1 || P_PHASE_FAST_CYC < 1) begin : g_chk_min
    $error("timing counts must be at least one cycle");
  end
  if (64'(P_PHASE_FAST_CYC) * 64'd8 > 64'd1 << CW || 64'(P_HOLD_FAST_CYC) * 64'd2 > 64'd1 << CW) begin : g_chk_max
    $error("timing counts exceed the phase counter");
  end

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [PIN_N-1:0] pins_lvl;
  logic [PIN_N-1:0] pins_raw;

  always_comb begin
    pins_raw            = '0;
    pins_raw[PIN_TRIG]  = i_watchdog_trigger_in;
    pins_raw[PIN_SEL_A] = i_timing_select_a;
    pins_raw[PIN_SEL_B] = i_timing_select_b;
    pins_raw[PIN_UV_O]  = i_vout_undervoltage;
    pins_raw[PIN_UV_I]  = i_vin_undervoltage;
  end

  // trigger idles high so no false edge is seen after reset
  wwdr_sync #(
    .W      (PIN_N),
    .P_INIT (PIN_INIT)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async (pins_raw),
    .o_level (pins_lvl)
  );

  logic trig_lvl;
  logic sel_a;
  logic sel_b;
  logic uv_out;
  logic uv_in;

  assign trig_lvl = pins_lvl[PIN_TRIG];
  assign sel_a    = pins_lvl[PIN_SEL_A];
  assign sel_b    = pins_lvl[PIN_SEL_B];
  assign uv_out   = pins_lvl[PIN_UV_O];
  assign uv_in    = pins_lvl[PIN_UV_I];

  // ---------------------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------------------
  wwdr_pkg::wwdr_mode_t wd_mode;
  logic                 hold_slow;

  always_comb begin
    unique case ({sel_a, sel_b})
      2'b00: wd_mode = wwdr_pkg::MODE_FAST;  // R13 R16
      2'b01: wd_mode = wwdr_pkg::MODE_SLOW;  // R16
      2'b10: wd_mode = wwdr_pkg::MODE_FAST;  // R16
      2'b11: wd_mode = wwdr_pkg::MODE_OFF;   // R16
    endcase
  end

  assign hold_slow = sel_a | sel_b;  // R17

  // ---------------------------------------------------------------------------
  // phase durations, last count of each phase
  // ---------------------------------------------------------------------------
  logic [CW-1:0] hold_last;
  logic [CW-1:0] phase_last;
  logic [CW-1:0] long_last;
  logic [CW-1:0] phase_len;

  always_comb begin
    // slow mode doubles every window
    phase_len  = (wd_mode == wwdr_pkg::MODE_SLOW) ? CW'(P_PHASE_FAST_CYC * 2)
                                                  : CW'(P_PHASE_FAST_CYC);  // R21
    phase_last = phase_len - CW'(1);
    long_last  = CW'(phase_len << wwdr_pkg::LONG_OPEN_SHIFT) - CW'(1);      // R04 R21
    hold_last  = hold_slow ? CW'(P_HOLD_FAST_CYC * 2 - 1)
                           : CW'(P_HOLD_FAST_CYC - 1);                      // R17
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  wwdr_pkg::wwdr_regs_t r_r;
  wwdr_pkg::wwdr_regs_t r_nxt;

  logic trig_fall;
  logic uv_any;
  logic apb_setup;
  logic apb_done;
  logic wr_ctrl;
  logic wr_cause;
  logic addr_ok;

  assign trig_fall = r_r.trig_prev & ~trig_lvl;                     // R06
  assign uv_any    = uv_out | (uv_in & r_r.uv_in_en);               // R14 R15
  assign apb_setup = i_psel & ~i_penable;
  assign apb_done  = i_psel & i_penable & r_r.pready;
  assign addr_ok   = (i_paddr == wwdr_pkg::OFS_CTRL) || (i_paddr == wwdr_pkg::OFS_STATUS) ||
                     (i_paddr == wwdr_pkg::OFS_CAUSE);
  assign wr_ctrl   = apb_done & i_pwrite & (i_paddr == wwdr_pkg::OFS_CTRL);
  assign wr_cause  = apb_done & i_pwrite & (i_paddr == wwdr_pkg::OFS_CAUSE);

  // ---------------------------------------------------------------------------
  // register read words
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] cause_word;

  // built from registered state, so a read reports the cycle of its setup phase
  always_comb begin
    ctrl_word   = 32'h0000_0000;
    status_word = 32'h0000_0000;
    cause_word  = 32'h0000_0000;
    ctrl_word[wwdr_pkg::CTRL_UV_IN_EN_BIT]     = r_r.uv_in_en;
    status_word[wwdr_pkg::STAT_STATE_LSB +: 3] = r_r.st;
    status_word[wwdr_pkg::STAT_RESET_BIT]      = r_r.rst_pin_b;
    status_word[wwdr_pkg::STAT_MODE_LSB +: 2]  = wd_mode;
    status_word[wwdr_pkg::STAT_RMODE_BIT]      = hold_slow;
    cause_word[wwdr_pkg::CAUSE_UV_BIT]         = r_r.cause[wwdr_pkg::CAUSE_UV_BIT];
    cause_word[wwdr_pkg::CAUSE_MISS_BIT]       = r_r.cause[wwdr_pkg::CAUSE_MISS_BIT];
    cause_word[wwdr_pkg::CAUSE_EARLY_BIT]      = r_r.cause[wwdr_pkg::CAUSE_EARLY_BIT];
  end

  // ---------------------------------------------------------------------------
  // phase expiry
  // ---------------------------------------------------------------------------
  logic hold_done;
  logic phase_done;
  logic long_done;

  // >= rather than == so a strap change that shortens a running phase ends it at once
  assign hold_done  = (r_r.cnt >= hold_last);
  assign phase_done = (r_r.cnt >= phase_last);
  assign long_done  = (r_r.cnt >= long_last);

  always_comb begin
    logic [2:0] cause_set;
    cause_set = 3'h0;
    r_nxt     = r_r;
    r_nxt.trig_prev = trig_lvl;
    r_nxt.cnt       = r_r.cnt + CW'(1);

    // -------------------------------------------------------------------------
    // window sequencer
    // -------------------------------------------------------------------------
    unique case (r_r.st)
      wwdr_pkg::ST_HOLD: begin
        if (uv_any) begin
          r_nxt.cnt = '0;                                           // R14 R15
        end else if (hold_done) begin
          r_nxt.cnt = '0;
          r_nxt.st  = (wd_mode == wwdr_pkg::MODE_OFF) ? wwdr_pkg::ST_OFF
                                                     : wwdr_pkg::ST_IGNORE;  // R01 R02 R19
        end
      end
      wwdr_pkg::ST_IGNORE: begin
        // trigger edges fall through unused here
        if (phase_done) begin                                       // R03
          r_nxt.cnt = '0;
          r_nxt.st  = wwdr_pkg::ST_LONG_OPEN;                       // R04
        end
      end
      wwdr_pkg::ST_LONG_OPEN: begin
        if (trig_fall) begin
          r_nxt.cnt = '0;
          r_nxt.st  = wwdr_pkg::ST_CLOSED;                          // R05
        end else if (long_done) begin
          cause_set[wwdr_pkg::CAUSE_MISS_BIT] = 1'b1;
          r_nxt.cnt = '0;
          r_nxt.st  = wwdr_pkg::ST_HOLD;                            // R07 R19
        end
      end
      wwdr_pkg::ST_CLOSED: begin
        if (trig_fall) begin
          cause_set[wwdr_pkg::CAUSE_EARLY_BIT] = 1'b1;
          r_nxt.cnt = '0;
          r_nxt.st  = wwdr_pkg::ST_HOLD;                            // R11 R19
        end else if (phase_done) begin
          r_nxt.cnt = '0;
          r_nxt.st  = wwdr_pkg::ST_OPEN;                            // R08
        end
      end
      wwdr_pkg::ST_OPEN: begin
        if (trig_fall) begin
          r_nxt.cnt = '0;
          r_nxt.st  = wwdr_pkg::ST_CLOSED;                          // R09 R20
        end else if (phase_done) begin
          cause_set[wwdr_pkg::CAUSE_MISS_BIT] = 1'b1;
          r_nxt.cnt = '0;
          r_nxt.st  = wwdr_pkg::ST_HOLD;                            // R10 R19
        end
      end
      wwdr_pkg::ST_OFF: begin
        // straps changed away from off restart the sequence cleanly
        r_nxt.cnt = '0;
        if (wd_mode != wwdr_pkg::MODE_OFF) begin
          r_nxt.st = wwdr_pkg::ST_IGNORE;                           // R13
        end
      end
      default: begin
        r_nxt.cnt = '0;
        r_nxt.st  = wwdr_pkg::ST_HOLD;
      end
    endcase

    // watchdog modes switched to off mid-sequence stop the window checking; undervoltage still forces the hold
    if (r_r.st != wwdr_pkg::ST_HOLD && r_r.st != wwdr_pkg::ST_OFF &&
        wd_mode == wwdr_pkg::MODE_OFF) begin
      r_nxt.cnt = '0;
      r_nxt.st  = wwdr_pkg::ST_OFF;                                 // R16
      cause_set = 3'h0;
    end

    // undervoltage overrides every phase
    if (uv_any) begin
      cause_set[wwdr_pkg::CAUSE_UV_BIT] = 1'b1;
      r_nxt.cnt = '0;
      r_nxt.st  = wwdr_pkg::ST_HOLD;                                // R14 R15
    end

    // reset output low exactly while holding; oe drives the open-drain pull-down
    r_nxt.rst_pin_b = (r_nxt.st != wwdr_pkg::ST_HOLD);              // R01 R10 R11 R14
    r_nxt.rst_oe    = (r_nxt.st == wwdr_pkg::ST_HOLD);

    // -------------------------------------------------------------------------
    // apb slave
    // -------------------------------------------------------------------------
    // ready is registered from the setup phase, so no wait state, and every bus output stays registered
    r_nxt.pready  = apb_setup;
    r_nxt.pslverr = apb_setup & ~addr_ok;
    r_nxt.prdata  = 32'h0000_0000;
    if (apb_setup && !i_pwrite) begin
      unique case (i_paddr)
        wwdr_pkg::OFS_CTRL: begin
          r_nxt.prdata = ctrl_word;
        end
        wwdr_pkg::OFS_STATUS: begin
          r_nxt.prdata = status_word;
        end
        wwdr_pkg::OFS_CAUSE: begin
          r_nxt.prdata = cause_word;
        end
        default: begin
          r_nxt.prdata = 32'h0000_0000;
        end
      endcase
    end
    if (wr_ctrl) begin
      r_nxt.uv_in_en = i_pwdata[wwdr_pkg::CTRL_UV_IN_EN_BIT];       // R15
    end
    // write one to clear; a cause arriving in the same cycle wins
    r_nxt.cause = (r_r.cause & ~(wr_cause ? i_pwdata[2:0] : 3'h0)) | cause_set;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_r <= '{st:        wwdr_pkg::ST_HOLD,
               cnt:       '0,
               trig_prev: 1'b1,
               rst_pin_b: 1'b0,
               rst_oe:    1'b1,
               uv_in_en:  P_OPT_LOW_VOUT,
               cause:     wwdr_pkg::CAUSE_RST,
               pready:    1'b0,
               pslverr:   1'b0,
               prdata:    32'h0000_0000};                           // R01
    end else begin
      r_r <= r_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign o_pready          = r_r.pready;
  assign o_pslverr         = r_r.pslverr;
  assign o_prdata          = r_r.prdata;
  assign o_reset_out_pin_b = r_r.rst_pin_b;
  assign o_reset_out_oe    = r_r.rst_oe;

endmodule : wwdr_top

// File: hw/wwdr_pkg.sv
package wwdr_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned HOLD_FAST_MS    = 16;
  localparam int unsigned PHASE_FAST_MS   = 32;
  localparam int unsigned HOLD_FAST_CYC   = HOLD_FAST_MS * CYC_PER_MS;
  localparam int unsigned PHASE_FAST_CYC  = PHASE_FAST_MS * CYC_PER_MS;
  localparam int unsigned LONG_OPEN_SHIFT = 2;   // long open phase is four open phases
  localparam int unsigned CNT_W           = 24;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CAUSE  = 12'h008;

  localparam int unsigned CTRL_UV_IN_EN_BIT = 0;
  localparam int unsigned STAT_STATE_LSB    = 0;
  localparam int unsigned STAT_RESET_BIT    = 4;
  localparam int unsigned STAT_MODE_LSB     = 8;
  localparam int unsigned STAT_RMODE_BIT    = 12;
  localparam int unsigned CAUSE_UV_BIT      = 0;
  localparam int unsigned CAUSE_MISS_BIT    = 1;
  localparam int unsigned CAUSE_EARLY_BIT   = 2;
  localparam logic [2:0]  CAUSE_RST         = 3'h0;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD      = 3'b000,
    ST_IGNORE    = 3'b001,
    ST_LONG_OPEN = 3'b010,
    ST_CLOSED    = 3'b011,
    ST_OPEN      = 3'b100,
    ST_OFF       = 3'b101
  } wwdr_state_t;

  typedef enum logic [1:0] {
    MODE_FAST = 2'b00,
    MODE_SLOW = 2'b01,
    MODE_OFF  = 2'b10
  } wwdr_mode_t;

  typedef struct packed {
    wwdr_state_t        st;
    logic [CNT_W-1:0]   cnt;
    logic               trig_prev;
    logic               rst_pin_b;
    logic               rst_oe;
    logic               uv_in_en;
    logic [2:0]         cause;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } wwdr_regs_t;

endpackage : wwdr_pkg

// File: hw/wwdr_sync.sv
`timescale 1ns/1ns

// three-stage synchroniser; a bit's level changes only once stages two and three agree
module wwdr_sync #(
  parameter int unsigned W      = 1,
  parameter logic [W-1:0] P_INIT = '0
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] lvl;
  } wwdr_sync_t;

  wwdr_sync_t s_r;
  wwdr_sync_t s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ff1 = i_async;
    s_nxt.ff2 = s_r.ff1;
    s_nxt.ff3 = s_r.ff2;
    // a disagreement between stages two and three is a possible glitch: keep the old level
    s_nxt.lvl = (s_r.ff2 & ~(s_r.ff2 ^ s_r.ff3)) | (s_r.lvl & (s_r.ff2 ^ s_r.ff3));
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_r <= '{ff1: P_INIT, ff2: P_INIT, ff3: P_INIT, lvl: P_INIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_level = s_r.lvl;

endmodule : wwdr_sync

// File: dv/wwdr_top_asserts.sv
`timescale 1ns/1ns
// --------
// port checker
// --------
module wwdr_chk #(
  parameter int unsigned P_HOLD_FAST_CYC = 20
) (
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [31:0] o_prdata,
  input wire logic        i_watchdog_trigger_in,
  input wire logic        i_timing_select_a,
  input wire logic        i_timing_select_b,
  input wire logic        i_vout_undervoltage,
  input wire logic        i_vin_undervoltage,
  input wire logic        o_reset_out_pin_b,
  input wire logic        o_reset_out_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // low-time counter; 24 bits outlast any hold
  logic [23:0] low_r;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_r <= 24'h000000;
    end else if (o_reset_out_pin_b) begin
      low_r <= 24'h000000;
    end else begin
      low_r <= low_r + 24'h000001;
    end
  end
  AST_READY_AFTER_SETUP: assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
  AST_READY_PULSE: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  AST_RDATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0) else $error("read data outside access");
  AST_OE_DRIVE: assert property (o_reset_out_oe == !o_reset_out_pin_b) else $error("drive enable mismatch");
  AST_UV_LOW: assert property (i_vout_undervoltage [*8] |-> !o_reset_out_pin_b) else $error("uv without reset");
  // a rise before the hold has run out would release the processor early
  AST_HOLD_MIN: assert property ($rose(o_reset_out_pin_b) |-> low_r >= P_HOLD_FAST_CYC - 1)
    else $error("reset hold too short");
  AST_IGNORE_HIGH: assert property (($rose(o_reset_out_pin_b) ##0
    (!i_vout_undervoltage && !i_vin_undervoltage) [*8]) |-> o_reset_out_pin_b) else $error("reset in ignore phase");
  cover property ($fell(o_reset_out_pin_b));
  cover property ($rose(o_reset_out_pin_b));
  cover property (o_pslverr);
endmodule : wwdr_chk

bind wwdr_top wwdr_chk #(.P_HOLD_FAST_CYC(P_HOLD_FAST_CYC)) u_chk (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_watchdog_trigger_in(i_watchdog_trigger_in),
  .i_timing_select_a(i_timing_select_a), .i_timing_select_b(i_timing_select_b),
  .i_vout_undervoltage(i_vout_undervoltage), .i_vin_undervoltage(i_vin_undervoltage),
  .o_reset_out_pin_b(o_reset_out_pin_b), .o_reset_out_oe(o_reset_out_oe));

// File: dv/wwdr_cpu_model.sv
`timescale 1ns/1ns
// --------
// processor side of the trigger pin
// --------
module wwdr_cpu_model (
  input  wire logic       i_clock,
  input  wire logic       i_fire,
  input  wire logic [7:0] i_width,
  output logic            o_trigger
);
  int   left_r = 0;
  logic low_r  = 1'b0;
  // the pin idles high between pulses
  assign o_trigger = ~low_r;
  // width kept above what the synchroniser needs, so no pulse is lost
  always @(posedge i_clock) begin
    if (i_fire) begin
      low_r  <= 1'b1;
      left_r <= i_width;
    end else if (left_r > 1) begin
      left_r <= left_r - 1;
    end else begin
      left_r <= 0;
      low_r  <= 1'b0;
    end
  end
endmodule : wwdr_cpu_model

// File: dv/tb_windowed_watchdog_reset.sv
`timescale 1ns/1ns
module tb_windowed_watchdog_reset;
  localparam int HOLD = 20;
  localparam int PH   = 40;
  logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        fire = 1'b0, sa = 1'b0, sb = 1'b0, uvo = 1'b0, uvi = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [7:0]  width = 8'h04;
  logic        pready, pslverr, trig, pin_b;
  int          failures = 0, samples_checked = 0, n;

  always #25 clock = ~clock;

  wwdr_cpu_model cpu (.i_clock(clock), .i_fire(fire), .i_width(width), .o_trigger(trig));
  wwdr_top #(.P_HOLD_FAST_CYC(HOLD), .P_PHASE_FAST_CYC(PH)) dut (
    .i_clock(clock), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_watchdog_trigger_in(trig), .i_timing_select_a(sa),
    .i_timing_select_b(sb), .i_vout_undervoltage(uvo), .i_vin_undervoltage(uvi),
    .o_reset_out_pin_b(pin_b), .o_reset_out_oe());

  // --------
  // helpers
  // --------
  task automatic results();
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic hang();
    failures++;
    results();
  endtask : hang

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
      if (k > 20) hang();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic stat(input logic [2:0] e);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[2:0], e);
  endtask : stat

  task automatic pulse();
    @(posedge clock);
    width <= 8'(4 + $urandom % 3);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask : pulse

  task automatic wpin(input logic lvl, input int lim);
    n = 0;
    while (pin_b !== lvl) begin
      @(posedge clock);
      n++;
      if (n > lim) hang();
    end
  endtask : wpin

  // expected {reset slow, watchdog mode} for strap pair i = {a, b}
  function automatic logic [2:0] mdl(input int i);
    int a = i / 2;
    int b = i % 2;
    int m = (a && b) ? 2 : (b ? 1 : 0);
    return {1'(a | b), 2'(m)};
  endfunction : mdl

  // --------
  // scenarios
  // --------
  initial begin
    #5000000;
    hang();
  end

  initial begin
    void'($urandom(32'h2A01));
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    wpin(1'b1, 40);
    chk(32'(n >= HOLD && n <= HOLD + 5), 32'h1);
    stat(3'h1);
    pulse();
    repeat (10) @(posedge clock);
    stat(3'h1);
    chk(pin_b, 1'b1);
    repeat (30) @(posedge clock);
    stat(3'h2);
    pulse();
    repeat (16) @(posedge clock);
    stat(3'h3);
    chk(pin_b, 1'b1);
    repeat (30) @(posedge clock);
    stat(3'h4);
    pulse();
    repeat (10) @(posedge clock);
    stat(3'h3);
    pulse();
    wpin(1'b0, 20);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[2:0], 3'h4);
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[2:0], 3'h0);
    wpin(1'b1, HOLD + 10);
    stat(3'h1);
    repeat (50) @(posedge clock);
    pulse();
    wpin(1'b0, 100);
    chk(32'(n > 60), 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[2:0], 3'h2);
    apb(1'b1, 12'h008, 32'h7);
    wpin(1'b1, 80);
    uvo <= 1'b1;
    repeat (10) @(posedge clock);
    chk(pin_b, 1'b0);
    uvo <= 1'b0;
    wpin(1'b1, 60);
    chk(32'(n >= HOLD), 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[0], 1'b0);
    uvi <= 1'b1;
    repeat (12) @(posedge clock);
    chk(pin_b, 1'b1);
    apb(1'b1, 12'h000, 32'h1);
    repeat (10) @(posedge clock);
    chk(pin_b, 1'b0);
    uvi <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    for (int i = 0; i < 4; i++) begin
      sa <= 1'(i / 2);
      sb <= 1'(i % 2);
      repeat (8) @(posedge clock);
      apb(1'b0, 12'h004, 32'h0);
      chk({rd[12], rd[9:8]}, mdl(i));
    end
    sa <= 1'b0;
    sb <= 1'b1;
    wpin(1'b1, 100);
    uvo <= 1'b1;
    repeat (10) @(posedge clock);
    uvo <= 1'b0;
    wpin(1'b1, 3 * HOLD);
    chk(32'(n >= 2 * HOLD), 32'h1);
    repeat (55) @(posedge clock);
    pulse();
    repeat (10) @(posedge clock);
    stat(3'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    results();
  end
endmodule : tb_windowed_watchdog_reset
